// >>> hdl/pdc_consts.vh
// Constants for the peripheral DMA channel pair.
// Assumes inclusion by the channel module only.
`ifndef PDC_CONSTS_VH
`define PDC_CONSTS_VH

`define PDC_ADDR_W       32
`define PDC_CNT_W        16
`define PDC_LIST_DISABLE 2'h0
`define PDC_LIST_ARRAY   2'h1
`define PDC_HTRANS_IDLE  2'h0
`define PDC_HTRANS_NSEQ  2'h2
`define PDC_HSIZE_BYTE   3'h0
`define PDC_HBURST_SGL   3'h0
`define PDC_RAM_BASE     32'h2000_0000
`define PDC_RAM_TOP      32'h2FFF_FFFF

`endif

// >>> hdl/pdc_channel.v
// Peripheral DMA channel pair: a read channel and a write channel sharing one AHB master port.
// Assumes an AHB-Lite layer of a multilayer interconnect on core_clk_i, byte-addressed RAM.
`timescale 1ns/100ps
`default_nettype none
`include "pdc_consts.vh"

// Operation
// [RULE1] AHB master toward RAM, never flash; code still addresses flash, only flagging bus_error_o
// [RULE2] Independent read and write channels, own settings
// [RULE3] Read channel fetches exactly max_byte_count bytes
// [RULE4] Write channel never exceeds max_byte_count
// [RULE5] Transferred byte count readable after completion
// [RULE6] Software sizes write count to buffer
// [RULE7] Software loads valid buffer pointer first
// [RULE8] Bad addresses not blocked; error just reported
// [RULE9] Channel stalls until bus grants access
// [RULE10] Array-list mode selected by list register
// [RULE11] Next item follows previous, no link
// [RULE12] Item full after max_byte_count bytes
// [RULE13] Interconnect grants by fixed master priority
// [RULE14] End event once transfers have finished
// [RULE15] Byte-sized transfers keep neighbours untouched
// [RULE16] Settings captured when transfer starts
module pdc_channel #(
    parameter CNT_W = `PDC_CNT_W
) (
    input  wire             core_clk_i,        // System clock
    input  wire             rst_i,             // Sync reset, active high
    // Read channel settings and control
    input  wire [31:0]      rd_buffer_pointer_i, // Read buffer start address
    input  wire [CNT_W-1:0] rd_max_byte_count_i, // Bytes to fetch
    input  wire [1:0]       rd_list_i,           // Read list-mode select
    input  wire             rd_start_i,          // Start read transfer pulse
    output reg  [CNT_W-1:0] rd_transferred_byte_count_o, // Bytes fetched
    output reg              rd_busy_o,           // Read transfer running
    output reg              rd_end_o,            // Read end event pulse
    output reg  [7:0]       rd_data_o,           // Fetched byte to peripheral
    output reg              rd_valid_o,          // Fetched byte valid pulse
    // Write channel settings and control
    input  wire [31:0]      wr_buffer_pointer_i, // Write buffer start address
    input  wire [CNT_W-1:0] wr_max_byte_count_i, // Byte limit
    input  wire [1:0]       wr_list_i,           // Write list-mode select
    input  wire             wr_start_i,          // Start write transfer pulse
    input  wire             wr_stop_i,           // Peripheral finished producing
    input  wire [7:0]       wr_data_i,           // Byte from peripheral
    input  wire             wr_valid_i,          // Byte offered
    output reg              wr_ready_o,          // Byte accepted at the previous edge
    output reg  [CNT_W-1:0] wr_transferred_byte_count_o, // Bytes written
    output reg              wr_busy_o,           // Write transfer running
    output reg              wr_end_o,            // Write end event pulse
    output reg              bus_error_o,         // Sticky-free error pulse
    // AHB-Lite master
    output reg  [31:0]      haddr_o,             // Address
    output reg  [1:0]       htrans_o,            // Transfer type
    output reg              hwrite_o,            // Write enable
    output reg  [2:0]       hsize_o,             // Always byte
    output reg  [2:0]       hburst_o,            // Always single
    output reg  [31:0]      hwdata_o,            // Write data
    input  wire [31:0]      hrdata_i,            // Read data
    input  wire             hready_i,            // Transfer done / grant
    input  wire             hresp_i              // Error response
);

    localparam ST_IDLE = 2'h0;
    localparam ST_ADDR = 2'h1;
    localparam ST_DATA = 2'h2;
    // Counter step at full counter width
    localparam [CNT_W-1:0] CNT_ONE = {{(CNT_W-1){1'b0}}, 1'b1};

    reg [1:0]       st_q;
    reg             op_wr_q;        // Current bus op is a write
    reg [1:0]       lane_q;         // Byte lane of data phase
    // Captured settings
    reg [31:0]      rd_ptr_q;
    reg [CNT_W-1:0] rd_max_q;
    reg             rd_arr_q;
    reg [CNT_W-1:0] rd_item_q;
    reg [31:0]      wr_ptr_q;
    reg [CNT_W-1:0] wr_max_q;
    reg             wr_arr_q;
    reg [CNT_W-1:0] wr_item_q;
    reg [7:0]       wr_byte_q;
    reg             wr_have_q;      // Byte staged for writing
    reg             wr_stop_q;

    wire rd_want = rd_busy_o && (rd_transferred_byte_count_o != rd_max_q);
    wire wr_want = wr_busy_o && wr_have_q;
    wire wr_full = (wr_transferred_byte_count_o + {{(CNT_W-1){1'b0}}, wr_have_q}) >= wr_max_q;

    // Flash and other non-RAM space are still addressed, only flagged as an error
    function in_ram;
        input [31:0] a;
        begin
            in_ram = (a >= `PDC_RAM_BASE) && (a <= `PDC_RAM_TOP); // [RULE1]
        end
    endfunction

    always @(posedge core_clk_i) begin
        if (rst_i) begin
            st_q <= ST_IDLE;
            op_wr_q <= 1'b0;
            lane_q <= 2'h0;
            rd_ptr_q <= 32'h0000_0000;
            rd_max_q <= {CNT_W{1'b0}};
            rd_arr_q <= 1'b0;
            rd_item_q <= {CNT_W{1'b0}};
            wr_ptr_q <= 32'h0000_0000;
            wr_max_q <= {CNT_W{1'b0}};
            wr_arr_q <= 1'b0;
            wr_item_q <= {CNT_W{1'b0}};
            wr_byte_q <= 8'h00;
            wr_have_q <= 1'b0;
            wr_stop_q <= 1'b0;
            rd_transferred_byte_count_o <= {CNT_W{1'b0}};
            rd_busy_o <= 1'b0;
            rd_end_o <= 1'b0;
            rd_data_o <= 8'h00;
            rd_valid_o <= 1'b0;
            wr_ready_o <= 1'b0;
            wr_transferred_byte_count_o <= {CNT_W{1'b0}};
            wr_busy_o <= 1'b0;
            wr_end_o <= 1'b0;
            bus_error_o <= 1'b0;
            haddr_o <= 32'h0000_0000;
            htrans_o <= `PDC_HTRANS_IDLE;
            hwrite_o <= 1'b0;
            hsize_o <= `PDC_HSIZE_BYTE;
            hburst_o <= `PDC_HBURST_SGL;
            hwdata_o <= 32'h0000_0000;
        end else begin
            rd_end_o <= 1'b0;
            rd_valid_o <= 1'b0;
            wr_ready_o <= 1'b0;
            wr_end_o <= 1'b0;
            bus_error_o <= 1'b0;
            // Independent starts; settings latched only here
            if (rd_start_i && !rd_busy_o) begin // [RULE2]
                rd_ptr_q <= rd_buffer_pointer_i; // [RULE16]
                rd_max_q <= rd_max_byte_count_i; // [RULE16]
                rd_arr_q <= (rd_list_i == `PDC_LIST_ARRAY); // [RULE10]
                rd_item_q <= {CNT_W{1'b0}};
                rd_transferred_byte_count_o <= {CNT_W{1'b0}};
                rd_busy_o <= 1'b1;
            end
            if (wr_start_i && !wr_busy_o) begin // [RULE2]
                wr_ptr_q <= wr_buffer_pointer_i; // [RULE16]
                wr_max_q <= wr_max_byte_count_i; // [RULE16]
                wr_arr_q <= (wr_list_i == `PDC_LIST_ARRAY); // [RULE10]
                wr_item_q <= {CNT_W{1'b0}};
                wr_transferred_byte_count_o <= {CNT_W{1'b0}};
                wr_have_q <= 1'b0;
                wr_stop_q <= 1'b0;
                wr_busy_o <= 1'b1;
            end
            // Accept one byte from peripheral while room remains
            if (wr_busy_o && !wr_have_q && wr_valid_i && !wr_ready_o && !wr_full) begin // [RULE4]
                wr_byte_q <= wr_data_i;
                wr_have_q <= 1'b1;
                wr_ready_o <= 1'b1;
            end
            if (wr_busy_o && wr_stop_i) begin
                wr_stop_q <= 1'b1;
            end
            // Completion: reads done, or write limit/stop with nothing staged
            if (rd_busy_o && !rd_want && st_q == ST_IDLE) begin
                rd_busy_o <= 1'b0;
                rd_end_o <= 1'b1; // [RULE14]
            end
            // Array-list item ends when the item counter reaches the count
            if (wr_busy_o && !wr_have_q && st_q == ST_IDLE &&
                (wr_stop_q ||
                 (wr_arr_q ? wr_item_q : wr_transferred_byte_count_o) >= wr_max_q)) begin // [RULE4] [RULE12]
                wr_busy_o <= 1'b0;
                wr_end_o <= 1'b1; // [RULE14]
            end
            case (st_q)
                ST_IDLE: begin
                    // Read channel wins over write when both ask
                    if (rd_want) begin
                        op_wr_q <= 1'b0;
                        haddr_o <= rd_ptr_q; // [RULE3]
                        lane_q <= rd_ptr_q[1:0];
                        hwrite_o <= 1'b0;
                        htrans_o <= `PDC_HTRANS_NSEQ; // [RULE1]
                        hsize_o <= `PDC_HSIZE_BYTE; // [RULE15]
                        st_q <= ST_ADDR;
                    end else if (wr_want) begin
                        op_wr_q <= 1'b1;
                        haddr_o <= wr_ptr_q;
                        lane_q <= wr_ptr_q[1:0];
                        hwrite_o <= 1'b1;
                        htrans_o <= `PDC_HTRANS_NSEQ;
                        hsize_o <= `PDC_HSIZE_BYTE; // [RULE15]
                        st_q <= ST_ADDR;
                    end
                end
                ST_ADDR: begin
                    // Address held until granted; interconnect priority decides
                    if (hready_i) begin // [RULE9] [RULE13]
                        htrans_o <= `PDC_HTRANS_IDLE;
                        hwdata_o <= {4{wr_byte_q}}; // [RULE15]
                        st_q <= ST_DATA;
                    end
                end
                default: begin
                    if (hready_i) begin // [RULE9]
                        st_q <= ST_IDLE;
                        // Error reported, not prevented; count still advances
                        if (hresp_i || !in_ram(haddr_o)) begin
                            bus_error_o <= 1'b1; // [RULE8]
                        end
                        if (!op_wr_q) begin
                            rd_data_o <= hrdata_i[{lane_q, 3'b000} +: 8];
                            rd_valid_o <= 1'b1;
                            rd_ptr_q <= rd_ptr_q + 32'h0000_0001; // [RULE11]
                            rd_transferred_byte_count_o <=
                                rd_transferred_byte_count_o + CNT_ONE; // [RULE3] [RULE5]
                            if (rd_arr_q && rd_item_q + CNT_ONE == rd_max_q) begin
                                rd_item_q <= {CNT_W{1'b0}}; // [RULE12]
                                rd_busy_o <= 1'b0;
                                rd_end_o <= 1'b1; // [RULE14]
                            end else begin
                                rd_item_q <= rd_item_q + CNT_ONE;
                            end
                        end else begin
                            wr_have_q <= 1'b0;
                            wr_ptr_q <= wr_ptr_q + 32'h0000_0001; // [RULE11]
                            wr_transferred_byte_count_o <=
                                wr_transferred_byte_count_o + CNT_ONE; // [RULE5]
                            wr_item_q <= wr_item_q + CNT_ONE; // [RULE12]
                        end
                    end
                end
            endcase
        end
    end

endmodule
`default_nettype wire

// >>> verification/pdc_ram_model.sv
// Byte-wide RAM slave on the channel's AHB-Lite port.
// Assumes single NONSEQ byte transfers; slow_i adds wait states.
`timescale 1ns/100ps
`default_nettype none
module pdc_ram_model (
    input  wire logic        core_clk_i, // Clock
    input  wire logic        rst_i,      // Reset
    input  wire logic        slow_i,     // Wait states
    input  wire logic [31:0] haddr_i,    // Address
    input  wire logic [1:0]  htrans_i,   // Type
    input  wire logic        hwrite_i,   // Write
    input  wire logic [31:0] hwdata_i,   // Write data
    output logic      [31:0] hrdata_o,   // Read data
    output logic             hready_o,   // Ready
    output logic             hresp_o     // Response
);
    logic [7:0] mem [0:255];
    logic [7:0] a_q;
    logic       ph_q, wr_q, tog_q;
    initial for (int i = 0; i < 256; i++) mem[i] = i[7:0] ^ 8'h5A;
    assign hready_o = !slow_i || tog_q;
    assign hresp_o  = 1'b0;
    // Garbage outside a valid data phase, never the last value
    assign hrdata_o = (ph_q && !wr_q && hready_o) ? {4{mem[a_q]}} : ~{4{mem[a_q]}};
    always @(posedge core_clk_i) begin
        tog_q <= !rst_i && !tog_q;
        if (rst_i) begin
            ph_q <= 1'b0;
        end else if (hready_o) begin
            if (ph_q && wr_q) mem[a_q] <= hwdata_i[8*a_q[1:0] +: 8];
            ph_q <= htrans_i[1];
            a_q  <= haddr_i[7:0];
            wr_q <= hwrite_i;
        end
    end
endmodule
`default_nettype wire

// >>> verification/pdc_channel_asserts.sv
// Port-level checker for the channel pair.
// Assumes binding onto every pdc_channel instance.
`timescale 1ns/100ps
`default_nettype none
module pdc_channel_asserts #(parameter CNT_W = 16) (
    input wire logic             core_clk_i,  // Clock
    input wire logic             rst_i,       // Reset
    input wire logic             rd_start_i,  // Read start
    input wire logic [CNT_W-1:0] rd_max_byte_count_i, // Read count
    input wire logic             rd_busy_o,   // Read busy
    input wire logic             rd_end_o,    // Read end
    input wire logic             rd_valid_o,  // Read byte
    input wire logic [CNT_W-1:0] rd_transferred_byte_count_o, // Read total
    input wire logic             wr_start_i,  // Write start
    input wire logic [CNT_W-1:0] wr_max_byte_count_i, // Write limit
    input wire logic             wr_busy_o,   // Write busy
    input wire logic [CNT_W-1:0] wr_transferred_byte_count_o, // Write total
    input wire logic [31:0]      haddr_o,     // Address
    input wire logic [1:0]       htrans_o,    // Type
    input wire logic [2:0]       hsize_o,     // Size
    input wire logic [2:0]       hburst_o,    // Burst
    input wire logic             hready_i     // Ready
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    logic [CNT_W-1:0] rd_cap_q, wr_cap_q;
    always @(posedge core_clk_i) begin
        if (rst_i) begin
            rd_cap_q <= '0;
            wr_cap_q <= '0;
        end else begin
            if (rd_start_i && !rd_busy_o) rd_cap_q <= rd_max_byte_count_i;
            if (wr_start_i && !wr_busy_o) wr_cap_q <= wr_max_byte_count_i;
        end
    end
    sequence s_gap; !rd_valid_o ##1 !rd_valid_o; endsequence
    property p_size; htrans_o != 2'h0 |-> hsize_o == 3'h0 && hburst_o == 3'h0; endproperty
    property p_hold; htrans_o == 2'h2 && !hready_i |=> htrans_o == 2'h2 && $stable(haddr_o); endproperty
    property p_single; htrans_o == 2'h2 && hready_i |=> htrans_o == 2'h0; endproperty
    property p_start; rd_start_i && !rd_busy_o |=> rd_busy_o; endproperty
    property p_end; rd_end_o |-> !rd_busy_o ##1 !rd_end_o; endproperty
    property p_rcnt; rd_end_o |-> rd_transferred_byte_count_o == rd_cap_q; endproperty
    property p_wlim; wr_busy_o |-> wr_transferred_byte_count_o <= wr_cap_q; endproperty
    property p_gap; rd_valid_o |=> s_gap; endproperty
    a_size: assert property (p_size) else $error("non-byte or burst transfer");
    a_hold: assert property (p_hold) else $error("address phase changed in wait");
    a_single: assert property (p_single) else $error("back-to-back bus transfers");
    a_start: assert property (p_start) else $error("read start not taken");
    a_end: assert property (p_end) else $error("read end pulse wrong");
    a_rcnt: assert property (p_rcnt) else $error("read total not captured count");
    a_wlim: assert property (p_wlim) else $error("write total over limit");
    a_gap: assert property (p_gap) else $error("read bytes closer than 3 cycles");
endmodule
bind pdc_channel pdc_channel_asserts #(.CNT_W(CNT_W)) pdc_channel_asserts_inst (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .rd_start_i(rd_start_i),
    .rd_max_byte_count_i(rd_max_byte_count_i), .rd_busy_o(rd_busy_o), .rd_end_o(rd_end_o),
    .rd_valid_o(rd_valid_o), .rd_transferred_byte_count_o(rd_transferred_byte_count_o),
    .wr_start_i(wr_start_i), .wr_max_byte_count_i(wr_max_byte_count_i), .wr_busy_o(wr_busy_o),
    .wr_transferred_byte_count_o(wr_transferred_byte_count_o), .haddr_o(haddr_o),
    .htrans_o(htrans_o), .hsize_o(hsize_o), .hburst_o(hburst_o), .hready_i(hready_i));
`default_nettype wire

// >>> verification/testbench.sv
// Self-checking bench for the channel pair against the RAM model.
// Assumes the checker is compiled alongside and bound in.
`timescale 1ns/100ps
`default_nettype none
module testbench;
    localparam logic [31:0] RAM = 32'h2000_0000;
    localparam logic [49:0] ROWS [0:3] = '{{RAM, 16'h5, 2'h0}, {RAM + 32'h3, 16'h1, 2'h0},
        {RAM, 16'h4, 2'h1}, {32'h1000_0002, 16'h2, 2'h0}};
    logic        core_clk_i = 0, rst_i = 1, slow = 0;
    logic [31:0] rd_buffer_pointer_i = '0, wr_buffer_pointer_i = '0, haddr_o, hwdata_o, hrdata_i;
    logic [15:0] rd_max_byte_count_i = '0, wr_max_byte_count_i = '0;
    logic [15:0] rd_transferred_byte_count_o, wr_transferred_byte_count_o;
    logic [1:0]  rd_list_i = '0, wr_list_i = '0, htrans_o;
    logic        rd_start_i = 0, wr_start_i = 0, wr_stop_i = 0, wr_valid_i = 0;
    logic [7:0]  wr_data_i = '0, rd_data_o;
    logic        rd_busy_o, rd_end_o, rd_valid_o, wr_ready_o, wr_busy_o, wr_end_o, bus_error_o;
    logic        hwrite_o, hready_i, hresp_i;
    logic [2:0]  hsize_o, hburst_o;
    logic [7:0]  shadow [0:255];
    int          failures = 0, compares = 0;
    pdc_channel pdc_channel_inst (.*);
    pdc_ram_model pdc_ram_model_inst (.core_clk_i(core_clk_i), .rst_i(rst_i), .slow_i(slow),
        .haddr_i(haddr_o), .htrans_i(htrans_o), .hwrite_i(hwrite_o), .hwdata_i(hwdata_o),
        .hrdata_o(hrdata_i), .hready_o(hready_i), .hresp_o(hresp_i));
    initial forever #2 core_clk_i = ~core_clk_i;
    task automatic tick;
        @(posedge core_clk_i);
        #1;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic summarize;
        $display("Comparisons %0d, mismatches %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic run_rd(input logic [31:0] ptr, input logic [15:0] cnt, input logic [1:0] lst);
        int n, t;
        logic err;
        n = 0;
        err = 0;
        {rd_buffer_pointer_i, rd_max_byte_count_i, rd_list_i, rd_start_i} = {ptr, cnt, lst, 1'b1};
        tick;
        // Retarget and restart while busy: must not disturb this transfer
        {rd_buffer_pointer_i, rd_max_byte_count_i} = {~ptr, cnt + 16'h3};
        tick;
        rd_start_i = 0;
        // Array-list end comes with the last byte, so bytes are taken before the end test
        for (t = 0; t < 400; t++) begin
            if (rd_valid_o === 1'b1) begin
                check(rd_data_o, shadow[ptr[7:0] + n[7:0]]);
                n++;
            end
            err = err | (bus_error_o === 1'b1);
            if (rd_end_o === 1'b1) break;
            tick;
        end
        check(rd_end_o, 1'b1);
        check(n, cnt);
        check(rd_transferred_byte_count_o, cnt);
        check(err, ptr < RAM);
    endtask
    task automatic run_wr(input logic [31:0] ptr, input logic [15:0] max, input int nb);
        int k, t, m;
        k = 0;
        m = nb < max ? nb : max;
        {wr_buffer_pointer_i, wr_max_byte_count_i, wr_start_i} = {ptr, max, 1'b1};
        {wr_data_i, wr_valid_i} = {8'hC0, 1'b1};
        tick;
        wr_start_i = 0;
        for (t = 0; t < 400 && wr_end_o !== 1'b1; t++) begin
            if (wr_ready_o === 1'b1) begin
                k++;
                wr_data_i = 8'hC0 + k[7:0];
                if (k == nb) {wr_valid_i, wr_stop_i} = 2'b01;
            end
            tick;
        end
        check(wr_end_o, 1'b1);
        {wr_valid_i, wr_stop_i} = 2'b00;
        check(k, m);
        check(wr_transferred_byte_count_o, m);
        for (t = 0; t < m; t++) shadow[ptr[7:0] + t[7:0]] = 8'hC0 + t[7:0];
        run_rd(ptr - 32'h1, 16'(m + 2), 2'h0);
    endtask
    initial begin
        for (int i = 0; i < 256; i++) shadow[i] = i[7:0] ^ 8'h5A;
        repeat (3) tick;
        check({rd_busy_o, wr_busy_o, rd_end_o, wr_end_o, bus_error_o, htrans_o}, '0);
        check({rd_transferred_byte_count_o, wr_transferred_byte_count_o}, '0);
        rst_i = 0;
        foreach (ROWS[i]) run_rd(ROWS[i][49:18], ROWS[i][17:2], ROWS[i][1:0]);
        slow = 1;
        run_rd(RAM + 32'h9, 16'h3, 2'h0);
        rd_start_i = 1;
        tick;
        rd_start_i = 0;
        repeat (2) tick;
        rst_i = 1;
        tick;
        rst_i = 0;
        check({rd_busy_o, htrans_o}, '0);
        // Write limit reached as a full array-list item
        wr_list_i = 2'h1;
        run_wr(RAM + 32'h5, 16'h6, 8);
        slow = 0;
        wr_list_i = 2'h0;
        run_wr(RAM + 32'h22, 16'h4, 2);
        summarize;
    end
    // Whole sequence needs well under 5000 cycles
    initial begin
        #100000;
        failures++;
        summarize;
    end
endmodule
`default_nettype wire
